// ### verilog/motion_pkt_pkg.sv
// constants for the motion-state packet payload framer
// assumes one clock (mclk) and a synchronous active-high reset
//
// Contract
// - id 36 body velocity, 12 bytes XYZ
// - id 37 acceleration, 12 bytes XYZ
// - id 37 acceleration keeps gravity included
// - id 38 body accel XYZ plus g-force
// - id 38 body acceleration excludes gravity
// - id 39 roll pitch heading, 12 bytes
// - id 40 quaternion scalar then vector, 16
// - id 41 nine matrix elements, row-major, 36
// - id 42 angular velocity XYZ, 12 bytes
// - id 43 angular acceleration XYZ, 12 bytes
package motion_pkt_pkg;

   // ==========================================================
   // packet identifiers
   localparam logic [7:0] ID_BODY_VEL    = 8'h24;
   localparam logic [7:0] ID_ACCEL       = 8'h25;
   localparam logic [7:0] ID_BODY_ACCEL  = 8'h26;
   localparam logic [7:0] ID_EULER       = 8'h27;
   localparam logic [7:0] ID_QUATERNION  = 8'h28;
   localparam logic [7:0] ID_DCM         = 8'h29;
   localparam logic [7:0] ID_ANG_VEL     = 8'h2A;
   localparam logic [7:0] ID_ANG_ACCEL   = 8'h2B;

   // ==========================================================
   // payload geometry
   localparam int         WORD_W         = 32;
   localparam int         MAX_WORDS      = 9;
   localparam int         IDX_W          = 6;
   localparam logic [5:0] LEN_12         = 6'h0C;
   localparam logic [5:0] LEN_16         = 6'h10;
   localparam logic [5:0] LEN_36         = 6'h24;
   localparam logic [5:0] LEN_NONE       = 6'h00;
   localparam logic [5:0] IDX_ZERO       = 6'h00;
   localparam logic [5:0] IDX_ONE        = 6'h01;

   typedef logic [MAX_WORDS-1:0][WORD_W-1:0] payload_t;

   // ==========================================================
   // helpers
   function automatic logic is_state_id(input logic [7:0] id);
      return (id >= ID_BODY_VEL) && (id <= ID_ANG_ACCEL);
   endfunction

   // word idx/4, byte idx%4; byte 0 of a field is its least significant byte
   function automatic logic [7:0] byte_at(input payload_t words, input logic [5:0] idx);
      logic [WORD_W-1:0] w;
      w = words[idx[5:2]];
      return w[{idx[1:0], 3'h0} +: 8];
   endfunction

endpackage

// ### verilog/motion_field_select.sv
// field selector: lays out the payload words and length for one packet id
// assumes purely combinational use inside the framer
module motion_field_select (
   input  wire logic [7:0]                    id,
   input  wire logic [2:0][31:0]              body_vel,
   input  wire logic [2:0][31:0]              accel_with_gravity,
   input  wire logic [2:0][31:0]              body_accel_no_gravity,
   input  wire logic [31:0]                   g_force,
   input  wire logic [2:0][31:0]              euler_rph,
   input  wire logic [31:0]                   scalar_part,
   input  wire logic [31:0]                   vector_part_first,
   input  wire logic [31:0]                   vector_part_second,
   input  wire logic [31:0]                   vector_part_third,
   input  wire logic [8:0][31:0]              dcm_elem,
   input  wire logic [2:0][31:0]              ang_vel,
   input  wire logic [2:0][31:0]              ang_accel,
   output motion_pkt_pkg::payload_t           words,
   output logic [5:0]                         len_bytes
);

   // ==========================================================
   // layout: word k sits at byte offset 4k, fields packed back to back
   always_comb begin
      words     = '0;
      len_bytes = motion_pkt_pkg::LEN_NONE;
      unique case (id)
         motion_pkt_pkg::ID_BODY_VEL: begin
            words[2:0] = body_vel;
            len_bytes  = motion_pkt_pkg::LEN_12;
         end
         motion_pkt_pkg::ID_ACCEL: begin
            words[2:0] = accel_with_gravity;
            len_bytes  = motion_pkt_pkg::LEN_12;
         end
         motion_pkt_pkg::ID_BODY_ACCEL: begin
            words[2:0] = body_accel_no_gravity;
            words[3]   = g_force;
            len_bytes  = motion_pkt_pkg::LEN_16;
         end
         motion_pkt_pkg::ID_EULER: begin
            words[2:0] = euler_rph;
            len_bytes  = motion_pkt_pkg::LEN_12;
         end
         motion_pkt_pkg::ID_QUATERNION: begin
            words[0]  = scalar_part;
            words[1]  = vector_part_first;
            words[2]  = vector_part_second;
            words[3]  = vector_part_third;
            len_bytes = motion_pkt_pkg::LEN_16;
         end
         motion_pkt_pkg::ID_DCM: begin
            words     = dcm_elem;
            len_bytes = motion_pkt_pkg::LEN_36;
         end
         motion_pkt_pkg::ID_ANG_VEL: begin
            words[2:0] = ang_vel;
            len_bytes  = motion_pkt_pkg::LEN_12;
         end
         motion_pkt_pkg::ID_ANG_ACCEL: begin
            words[2:0] = ang_accel;
            len_bytes  = motion_pkt_pkg::LEN_12;
         end
         default: begin
            words     = '0;
            len_bytes = motion_pkt_pkg::LEN_NONE;
         end
      endcase
   end

endmodule // motion_field_select

// ### verilog/motion_state_framer.sv
// motion-state packet payload framer: snapshots fields, streams payload bytes
// assumes field inputs and handshakes are synchronous to mclk
module motion_state_framer (
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   input  wire logic                 req_valid,
   input  wire logic [7:0]           req_id,
   output logic                      req_ready_r,
   output logic                      req_refused_r,
   input  wire logic [2:0][31:0]     body_vel,
   input  wire logic [2:0][31:0]     accel_with_gravity,
   input  wire logic [2:0][31:0]     body_accel_no_gravity,
   input  wire logic [31:0]          g_force,
   input  wire logic [2:0][31:0]     euler_rph,
   input  wire logic [31:0]          scalar_part,
   input  wire logic [31:0]          vector_part_first,
   input  wire logic [31:0]          vector_part_second,
   input  wire logic [31:0]          vector_part_third,
   input  wire logic [8:0][31:0]     dcm_elem,
   input  wire logic [2:0][31:0]     ang_vel,
   input  wire logic [2:0][31:0]     ang_accel,
   output logic [7:0]                pkt_id_r,
   output logic [5:0]                pkt_len_r,
   output logic                      out_valid_r,
   output logic [7:0]                out_byte_r,
   output logic                      out_last_r,
   input  wire logic                 out_ready,
   input  wire logic                 host_pkt_valid,
   input  wire logic [7:0]           host_pkt_id,
   output logic                      host_write_ignored_r
);

   typedef enum logic {ST_IDLE, ST_SEND} state_t;

   state_t                           state_r;
   state_t                           state_nxt;
   motion_pkt_pkg::payload_t         words_r;
   motion_pkt_pkg::payload_t         words_nxt;
   motion_pkt_pkg::payload_t         sel_words;
   logic [5:0]                       sel_len;
   logic [5:0]                       idx_r;
   logic [5:0]                       idx_nxt;
   logic                             req_ready_nxt;
   logic                             req_refused_nxt;
   logic [7:0]                       pkt_id_nxt;
   logic [5:0]                       pkt_len_nxt;
   logic                             out_valid_nxt;
   logic [7:0]                       out_byte_nxt;
   logic                             out_last_nxt;
   logic                             host_write_ignored_nxt;
   logic                             take;
   logic                             accept;
   logic                             byte_go;
   logic                             finish;

   // ==========================================================
   // payload layout
   motion_field_select u_select (
      .id                    (req_id),
      .body_vel              (body_vel),
      .accel_with_gravity    (accel_with_gravity),
      .body_accel_no_gravity (body_accel_no_gravity),
      .g_force               (g_force),
      .euler_rph             (euler_rph),
      .scalar_part           (scalar_part),
      .vector_part_first     (vector_part_first),
      .vector_part_second    (vector_part_second),
      .vector_part_third     (vector_part_third),
      .dcm_elem              (dcm_elem),
      .ang_vel               (ang_vel),
      .ang_accel             (ang_accel),
      .words                 (sel_words),
      .len_bytes             (sel_len)
   );

   // ==========================================================
   // handshake decode
   // a taken request whose id lies outside the state range is only refused
   always_comb begin
      take    = (state_r == ST_IDLE) && req_valid && req_ready_r;
      accept  = take && motion_pkt_pkg::is_state_id(req_id);
      byte_go = (state_r == ST_SEND) && out_valid_r && out_ready;
      finish  = byte_go && out_last_r;
   end

   // ==========================================================
   // control: sequencer state, request ready, refusal pulse
   // one packet at a time: ready stays low from acceptance to the last byte
   always_comb begin
      state_nxt       = state_r;
      req_ready_nxt   = req_ready_r;
      req_refused_nxt = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            // ready rises in idle even while a request waits, so a request
            // already raised during reset cannot lock the handshake
            req_ready_nxt = 1'b1;
            if (accept) begin
               state_nxt     = ST_SEND;
               req_ready_nxt = 1'b0;
            end else if (take) begin
               req_refused_nxt = 1'b1;
            end
         end
         ST_SEND: begin
            if (finish) begin
               state_nxt     = ST_IDLE;
               req_ready_nxt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r       <= ST_IDLE;
         req_ready_r   <= 1'b0;
         req_refused_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         req_ready_r   <= req_ready_nxt;
         req_refused_r <= req_refused_nxt;
      end
   end

   // ==========================================================
   // snapshot
   // the whole payload is captured at acceptance so a packet never
   // mixes fields from two navigation epochs, at the cost of 288 flops
   always_comb begin
      words_nxt   = words_r;
      pkt_id_nxt  = pkt_id_r;
      pkt_len_nxt = pkt_len_r;
      if (accept) begin
         words_nxt   = sel_words;
         pkt_id_nxt  = req_id;
         pkt_len_nxt = sel_len;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         words_r   <= '0;
         pkt_id_r  <= 8'h00;
         pkt_len_r <= motion_pkt_pkg::LEN_NONE;
      end else begin
         words_r   <= words_nxt;
         pkt_id_r  <= pkt_id_nxt;
         pkt_len_r <= pkt_len_nxt;
      end
   end

   // ==========================================================
   // byte stream
   // the sink may stall any byte; byte and last flag stand until taken
   always_comb begin
      idx_nxt       = idx_r;
      out_valid_nxt = out_valid_r;
      out_byte_nxt  = out_byte_r;
      out_last_nxt  = out_last_r;
      if (accept) begin
         idx_nxt       = motion_pkt_pkg::IDX_ZERO;
         out_valid_nxt = 1'b1;
         out_byte_nxt  = motion_pkt_pkg::byte_at(sel_words, motion_pkt_pkg::IDX_ZERO);
         out_last_nxt  = 1'b0;
      end else if (finish) begin
         out_valid_nxt = 1'b0;
         out_last_nxt  = 1'b0;
      end else if (byte_go) begin
         idx_nxt      = idx_r + motion_pkt_pkg::IDX_ONE;
         out_byte_nxt = motion_pkt_pkg::byte_at(words_r, idx_nxt);
         out_last_nxt = (idx_nxt == (pkt_len_r - motion_pkt_pkg::IDX_ONE));
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         idx_r       <= motion_pkt_pkg::IDX_ZERO;
         out_valid_r <= 1'b0;
         out_byte_r  <= 8'h00;
         out_last_r  <= 1'b0;
      end else begin
         idx_r       <= idx_nxt;
         out_valid_r <= out_valid_nxt;
         out_byte_r  <= out_byte_nxt;
         out_last_r  <= out_last_nxt;
      end
   end

   // ==========================================================
   // host-to-device path
   // these packets are read-only, so a host write only raises a notice
   always_comb begin
      host_write_ignored_nxt = host_pkt_valid && motion_pkt_pkg::is_state_id(host_pkt_id);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         host_write_ignored_r <= 1'b0;
      end else begin
         host_write_ignored_r <= host_write_ignored_nxt;
      end
   end

endmodule // motion_state_framer

// ### sim/motion_state_framer_properties.sv
// checker for the motion-state framer, watching its ports only
// assumes one clock domain, mclk, with sys_rst synchronous active high
module motion_state_checker (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic       req_valid,
   input wire logic [7:0] req_id,
   input wire logic       req_ready_r,
   input wire logic       req_refused_r,
   input wire logic [7:0] pkt_id_r,
   input wire logic [5:0] pkt_len_r,
   input wire logic       out_valid_r,
   input wire logic [7:0] out_byte_r,
   input wire logic       out_last_r,
   input wire logic       out_ready,
   input wire logic       host_pkt_valid,
   input wire logic [7:0] host_pkt_id,
   input wire logic       host_write_ignored_r
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // helper logic
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic       take;
   logic       ok_id;
   logic [5:0] taken_r;
   logic [5:0] taken_nxt;
   assign take  = req_valid && req_ready_r;
   assign ok_id = req_id >= 8'h24 && req_id <= 8'h2B;
   // bytes taken so far in the packet that streams
   always_comb begin
      taken_nxt = taken_r;
      if (take)
         taken_nxt = 6'h00;
      else if (out_valid_r && out_ready)
         taken_nxt = taken_r + 6'h01;
   end
   always_ff @(posedge mclk) begin
      taken_r <= sys_rst ? 6'h00 : taken_nxt;
   end
   function automatic logic [5:0] plen(logic [7:0] id);
      return (id == 8'h26 || id == 8'h28) ? 6'h10 : (id == 8'h29) ? 6'h24 : 6'h0C;
   endfunction
   // ==========================================
   // properties
   start_on_take_a: assert property (take && ok_id |=> out_valid_r && pkt_id_r == $past(req_id))
      else $error("accepted packet did not start");
   payload_length_a: assert property (take && ok_id |=> pkt_len_r == plen($past(req_id)))
      else $error("wrong payload length");
   refuse_pulse_a: assert property (take && !ok_id |=> req_refused_r && !out_valid_r ##1 !req_refused_r)
      else $error("bad id not refused in one pulse");
   stall_hold_a: assert property (out_valid_r && !out_ready |=> out_valid_r && $stable(out_byte_r) && $stable(out_last_r))
      else $error("byte changed while stalled");
   last_count_a: assert property (out_valid_r && out_last_r |-> taken_r == pkt_len_r - 6'h01)
      else $error("last byte at wrong count");
   end_release_a: assert property (out_valid_r && out_ready && out_last_r |=> !out_valid_r && req_ready_r)
      else $error("stream did not end after last byte");
   busy_not_ready_a: assert property (out_valid_r |-> !req_ready_r)
      else $error("ready while streaming");
   host_flag_a: assert property (host_pkt_valid |=> host_write_ignored_r == ($past(host_pkt_id) >= 8'h24 && $past(host_pkt_id) <= 8'h2B))
      else $error("host write flag wrong");
   host_idle_a: assert property (!host_pkt_valid |=> !host_write_ignored_r)
      else $error("host write flag without a packet");
   cover property (take && req_id == 8'h29);
   cover property (out_valid_r && !out_ready);
   cover property (take && !ok_id);
endmodule // motion_state_checker

bind motion_state_framer motion_state_checker chk_u (
   .mclk                 (mclk),
   .sys_rst              (sys_rst),
   .req_valid            (req_valid),
   .req_id               (req_id),
   .req_ready_r          (req_ready_r),
   .req_refused_r        (req_refused_r),
   .pkt_id_r             (pkt_id_r),
   .pkt_len_r            (pkt_len_r),
   .out_valid_r          (out_valid_r),
   .out_byte_r           (out_byte_r),
   .out_last_r           (out_last_r),
   .out_ready            (out_ready),
   .host_pkt_valid       (host_pkt_valid),
   .host_pkt_id          (host_pkt_id),
   .host_write_ignored_r (host_write_ignored_r)
);

// ### sim/host_sink_model.sv
// byte sink standing in for the host parser; stalls every other cycle on request
// assumes the framer's out_* handshake on mclk; clr empties it
module host_sink_model (
   input  wire logic       mclk,
   input  wire logic       clr,
   input  wire logic       stall,
   input  wire logic       out_valid_r,
   input  wire logic [7:0] out_byte_r,
   input  wire logic       out_last_r,
   output logic            out_ready,
   output logic            done,
   output int              got_n,
   output logic [7:0]      got [36]
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      out_ready = 1'b1;
      done = 1'b0;
      got_n = 0;
   end
   always @(posedge mclk) begin
      if (clr) begin
         got_n <= 0;
         done <= 1'b0;
      end else if (out_valid_r && out_ready && !done && got_n < 36) begin
         got[got_n] <= out_byte_r;
         got_n <= got_n + 1;
         done <= out_last_r;
      end
      out_ready <= #1 stall ? !out_ready : 1'b1;
   end
endmodule // host_sink_model

// ### sim/tb_top.sv
// self-checking bench for the motion-state framer
// assumes the sink model and the bound checker; fields get a distinct word each
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0][31:0] body_vel, accel_with_gravity, body_accel_no_gravity, euler_rph, ang_vel, ang_accel;
   logic [31:0]      g_force, scalar_part, vector_part_first, vector_part_second, vector_part_third;
   logic [8:0][31:0] dcm_elem;
   logic             mclk, sys_rst, req_valid, out_ready, host_pkt_valid, stall, clr, done;
   logic             req_ready_r, req_refused_r, out_valid_r, out_last_r, host_write_ignored_r;
   logic [7:0]       req_id, host_pkt_id, pkt_id_r, out_byte_r;
   logic [5:0]       pkt_len_r;
   logic [7:0]       got [36];
   int               got_n, failures, compares, cyc;
   motion_state_framer dut_u (
      .mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid), .req_id(req_id),
      .req_ready_r(req_ready_r), .req_refused_r(req_refused_r), .body_vel(body_vel),
      .accel_with_gravity(accel_with_gravity), .body_accel_no_gravity(body_accel_no_gravity),
      .g_force(g_force), .euler_rph(euler_rph), .scalar_part(scalar_part),
      .vector_part_first(vector_part_first), .vector_part_second(vector_part_second),
      .vector_part_third(vector_part_third), .dcm_elem(dcm_elem), .ang_vel(ang_vel),
      .ang_accel(ang_accel), .pkt_id_r(pkt_id_r), .pkt_len_r(pkt_len_r), .out_valid_r(out_valid_r),
      .out_byte_r(out_byte_r), .out_last_r(out_last_r), .out_ready(out_ready),
      .host_pkt_valid(host_pkt_valid), .host_pkt_id(host_pkt_id), .host_write_ignored_r(host_write_ignored_r)
   );
   host_sink_model sink_u (
      .mclk(mclk), .clr(clr), .stall(stall), .out_valid_r(out_valid_r), .out_byte_r(out_byte_r),
      .out_last_r(out_last_r), .out_ready(out_ready), .done(done), .got_n(got_n), .got(got)
   );
   // ==========================================
   // helpers
   function automatic logic [31:0] w(int g, int k, logic [7:0] s);
      return {8'h10 + 8'(g), s, 8'h30 + 8'(k), 8'hC5};
   endfunction
   function automatic logic [31:0] exp_w(logic [7:0] id, int i, logic [7:0] s);
      int grp [8] = '{0, 1, 2, 4, 5, 9, 10, 11};
      if (id == 8'h28)
         return w(5 + i, 0, s);
      if (id == 8'h26 && i == 3)
         return w(3, 0, s);
      return w(grp[id - 8'h24], i, s);
   endfunction
   function automatic int len_of(logic [7:0] id);
      return (id == 8'h26 || id == 8'h28) ? 16 : (id == 8'h29) ? 36 : 12;
   endfunction
   task automatic fill(logic [7:0] s);
      for (int k = 0; k < 3; k++) begin
         body_vel[k] = w(0, k, s);
         accel_with_gravity[k] = w(1, k, s);
         body_accel_no_gravity[k] = w(2, k, s);
         euler_rph[k] = w(4, k, s);
         ang_vel[k] = w(10, k, s);
         ang_accel[k] = w(11, k, s);
      end
      g_force = w(3, 0, s);
      scalar_part = w(5, 0, s);
      vector_part_first = w(6, 0, s);
      vector_part_second = w(7, 0, s);
      vector_part_third = w(8, 0, s);
      for (int k = 0; k < 9; k++) dcm_elem[k] = w(9, k, s);
   endtask
   task automatic chk(logic [31:0] got_v, logic [31:0] exp_v);
      compares++;
      if (got_v !== exp_v) begin
         failures++;
         $display("unexpected t=%0t got %h exp %h", $time, got_v, exp_v);
      end
   endtask
   task results();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // request held until taken; fields change right after, so the snapshot is tested
   task automatic send(logic [7:0] id, logic [7:0] s);
      int n;
      clr = 1'b1;
      fill(s);
      req_id = id;
      req_valid = 1'b1;
      n = 0;
      // ready only moves on an edge, so a settled high here means the next edge takes it
      while (req_ready_r !== 1'b1 && n < 50) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 50) begin
         failures++;
         $display("unexpected t=%0t req_ready_r %h exp %h", $time, req_ready_r, 1'b1);
      end
      @(posedge mclk);
      #1 req_valid = 1'b0;
      clr = 1'b0;
      fill(s + 8'h01);
   endtask
   // ==========================================
   // scenarios
   task automatic pkt(logic [7:0] id, logic [7:0] s, logic st);
      int n;
      logic [31:0] e;
      stall = st;
      send(id, s);
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 200) begin
         failures++;
         $display("unexpected t=%0t done %h exp %h", $time, done, 1'b1);
      end
      chk(pkt_id_r, id);
      chk(pkt_len_r, len_of(id));
      chk(got_n, len_of(id));
      for (int i = 0; i < got_n; i++) begin
         e = exp_w(id, i / 4, s);
         chk(got[i], e[8 * (i % 4) +: 8]);
      end
   endtask
   task automatic refuse(logic [7:0] id);
      send(id, 8'h77);
      chk({req_refused_r, out_valid_r}, 2'b10);
      @(posedge mclk);
      #1;
   endtask
   task automatic host(logic [7:0] id, logic flag);
      host_pkt_valid = 1'b1;
      host_pkt_id = id;
      @(posedge mclk);
      #1 host_pkt_valid = 1'b0;
      chk(host_write_ignored_r, flag);
      chk({req_ready_r, out_valid_r}, 2'b10);
      @(posedge mclk);
      #1;
      chk(host_write_ignored_r, 1'b0);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         results();
      end
   end
   initial begin
      {sys_rst, req_valid, host_pkt_valid, stall, clr, req_id, host_pkt_id} = {1'b1, 20'h00000};
      fill(8'h00);
      repeat (6) @(posedge mclk);
      #1 sys_rst = 1'b0;
      @(posedge mclk);
      #1 host(8'h28, 1'b1);
      host(8'h2C, 1'b0);
      host(8'h24, 1'b1);
      host(8'h23, 1'b0);
      pkt(8'h24, 8'h01, 1'b0);
      pkt(8'h25, 8'h03, 1'b1);
      pkt(8'h26, 8'h05, 1'b0);
      pkt(8'h27, 8'h07, 1'b1);
      pkt(8'h28, 8'h09, 1'b0);
      pkt(8'h29, 8'h0B, 1'b1);
      pkt(8'h2A, 8'h0D, 1'b0);
      pkt(8'h2B, 8'h0F, 1'b1);
      refuse(8'h23);
      refuse(8'h2C);
      results();
   end
endmodule // tb_top
